// File: core/frpc_reset_poweron.sv
// Reset and power-on sequencer of a serial flash device.
// Assumes resetPinN, selectN and supply flags come asynchronously from pins
// or analogue comparators; the operation code comes from core logic.
`timescale 1ns/100ps
`default_nettype none
module frpc_reset_poweron
    import frpc_pkg::*;
#(
    parameter int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_4K_RECOVERY_CYC,
    parameter int unsigned BLOCK_ERASE_CYC = BLOCK_ERASE_RECOVERY_CYC,
    parameter int unsigned CHIP_ERASE_CYC = CHIP_ERASE_RECOVERY_CYC,
    parameter int unsigned STATUS_WRITE_CYC = STATUS_CONFIG_WRITE_RECOVERY_CYC,
    parameter int unsigned SETTLE_CYC = SUPPLY_SETTLE_DELAY_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic resetPinN,
    input wire logic selectN,
    input wire logic supplyAboveInhibit,
    input wire logic supplyAboveMin,
    input wire logic [2:0] activeOp,
    input wire logic coreDataOut,
    input wire logic coreDataOutEn,
    output logic dataOut,
    output logic dataOutEn,
    output logic coreResetN,
    output logic abortOp,
    output logic busy,
    output logic commandEnable,
    output logic readEnable,
    output logic writeEnableLatchClear,
    output logic addr4Byte,
    output logic deepPowerDown
);
    logic rstPinSync;
    logic selSync;
    logic supInhSync;
    logic supMinSync;
    frpc_state_e state;
    frpc_state_e next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] next_target;
    logic [2:0] heldOp;
    logic [2:0] next_heldOp;
    logic next_abortOp;
    logic next_dataOut;
    logic next_dataOutEn;

    frpc_sync3 #(.RESET_VAL(1'b1)) uRst (
        .mclk(mclk), .rstn(rstn), .pin(resetPinN), .level(rstPinSync));
    frpc_sync3 #(.RESET_VAL(1'b1)) uSel (
        .mclk(mclk), .rstn(rstn), .pin(selectN), .level(selSync));
    frpc_sync3 #(.RESET_VAL(1'b0)) uInh (
        .mclk(mclk), .rstn(rstn), .pin(supplyAboveInhibit),
        .level(supInhSync));
    frpc_sync3 #(.RESET_VAL(1'b0)) uMin (
        .mclk(mclk), .rstn(rstn), .pin(supplyAboveMin), .level(supMinSync));

    // Recovery length chosen by what the reset interrupted
    function automatic logic [CNT_W-1:0] recoverLen(input logic [2:0] op);
        logic [CNT_W-1:0] r;
        r = CNT_W'(DECODE_RECOVERY_CYC);
        case (op)
            OP_READ: r = CNT_W'(READ_RECOVERY_CYC);
            OP_PROGRAM: r = CNT_W'(PROGRAM_RECOVERY_CYC);
            OP_SECTOR_ERASE_4K: r = CNT_W'(SECTOR_ERASE_CYC);
            OP_BLOCK_ERASE: r = CNT_W'(BLOCK_ERASE_CYC);
            OP_CHIP_ERASE: r = CNT_W'(CHIP_ERASE_CYC);
            OP_STATUS_CONFIG_WRITE: r = CNT_W'(STATUS_WRITE_CYC);
            default: r = CNT_W'(DECODE_RECOVERY_CYC);
        endcase
        return r;
    endfunction : recoverLen

    // Sequencer: brown-out overrides everything
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_target = target;
        next_heldOp = heldOp;
        next_abortOp = 1'b0;
        case (state)
            FRPC_POWER_OFF:
            begin
                next_count = '0;
                if (supMinSync)
                begin
                    next_state = FRPC_SETTLE;
                end
            end
            FRPC_SETTLE:
            begin
                next_count = count + 1'b1;
                if (count >= CNT_W'(SETTLE_CYC) - 1'b1)
                begin
                    // Power-on recovery then standby
                    next_state = FRPC_RECOVER;
                    next_target = CNT_W'(POWERON_RECOVERY_CYC);
                    next_count = '0;
                end
            end
            FRPC_STANDBY:
            begin
                next_count = '0;
                if (!rstPinSync)
                begin
                    next_state = FRPC_RESET_LOW;
                    next_heldOp = activeOp;
                    // Kill any program or erase at once
                    next_abortOp = activeOp >= OP_PROGRAM;
                end
            end
            FRPC_RESET_LOW:
            begin
                if (count < CNT_W'(RESET_LOW_WIDTH_CYC))
                begin
                    next_count = count + 1'b1;
                end
                if (rstPinSync)
                begin
                    next_count = '0;
                    // Short glitch: no reset, back to standby.
                    // Count starts one edge after the synced fall, so the
                    // threshold is one less and a pulse of exactly the minimum resets.
                    if (count >= CNT_W'(RESET_LOW_WIDTH_CYC) - 1'b1)
                    begin
                        next_state = FRPC_RECOVER;
                        next_target = recoverLen(heldOp);
                    end
                    else
                    begin
                        next_state = FRPC_STANDBY;
                    end
                end
            end
            FRPC_RECOVER:
            begin
                next_count = count + 1'b1;
                if (count >= target - 1'b1)
                begin
                    next_state = FRPC_STANDBY;
                    next_count = '0;
                end
                if (!rstPinSync)
                begin
                    next_state = FRPC_RESET_LOW;
                    next_heldOp = OP_DECODE;
                    next_count = '0;
                end
            end
            default:
            begin
                next_state = FRPC_POWER_OFF;
            end
        endcase
        if (!supInhSync)
        begin
            next_state = FRPC_POWER_OFF;
            next_count = '0;
            next_abortOp = activeOp >= OP_PROGRAM;
        end
    end

    // Serial output floats while reset pin is low
    always_comb
    begin
        next_dataOut = coreDataOut;
        next_dataOutEn = coreDataOutEn && commandEnable && !selSync;
        if (!rstPinSync || state == FRPC_RESET_LOW)
        begin
            next_dataOutEn = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state <= FRPC_POWER_OFF;
            count <= '0;
            target <= '0;
            heldOp <= OP_IDLE;
            abortOp <= 1'b0;
            dataOut <= 1'b0;
            dataOutEn <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            target <= next_target;
            heldOp <= next_heldOp;
            abortOp <= next_abortOp;
            dataOut <= next_dataOut;
            dataOutEn <= next_dataOutEn;
        end
    end

    // Status decode; commands only in standby
    assign commandEnable = state == FRPC_STANDBY;
    assign readEnable = commandEnable;
    assign busy = state != FRPC_STANDBY;
    assign coreResetN = state == FRPC_STANDBY;
    assign writeEnableLatchClear = !coreResetN;
    assign addr4Byte = 1'b0;
    assign deepPowerDown = 1'b0;

    property p_float;
        @(posedge mclk) disable iff (!rstn)
        (state == FRPC_RESET_LOW) |=> !dataOutEn;
    endproperty
    a_float: assert property (p_float) else $error("output driven in reset");

    property p_abort;
        @(posedge mclk) disable iff (!rstn)
        (state == FRPC_STANDBY && !rstPinSync && supInhSync
            && activeOp >= OP_PROGRAM) |=> abortOp;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on reset");

    property p_glitch;
        @(posedge mclk) disable iff (!rstn)
        (state == FRPC_RESET_LOW && rstPinSync && supInhSync
            && count < CNT_W'(RESET_LOW_WIDTH_CYC) - 1'b1)
            |=> state == FRPC_STANDBY;
    endproperty
    a_glitch: assert property (p_glitch) else $error("short pulse reset");

    property p_inhibit;
        @(posedge mclk) disable iff (!rstn)
        !supInhSync |=> (state == FRPC_POWER_OFF && !commandEnable);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("live below inhibit");

    property p_recover;
        @(posedge mclk) disable iff (!rstn)
        (state == FRPC_RECOVER) |-> (busy && !commandEnable);
    endproperty
    a_recover: assert property (p_recover) else $error("ready in recovery");

    // Select activity in recovery must not turn the output on
    property p_deaf;
        @(posedge mclk) disable iff (!rstn)
        (state == FRPC_RECOVER) |=> !dataOutEn;
    endproperty
    a_deaf: assert property (p_deaf) else $error("select heard in recovery");

    property p_poweron;
        @(posedge mclk) disable iff (!rstn)
        (state == FRPC_SETTLE && $past(state) == FRPC_SETTLE
            && next_state == FRPC_RECOVER)
            |=> target == CNT_W'(POWERON_RECOVERY_CYC);
    endproperty
    a_poweron: assert property (p_poweron) else $error("bad power-on time");

    property p_standby;
        @(posedge mclk) disable iff (!rstn)
        (state == FRPC_RECOVER && $past(state) == FRPC_RESET_LOW)
            |-> target == recoverLen(heldOp);
    endproperty
    a_standby: assert property (p_standby) else $error("bad recovery time");

    property p_defaults;
        @(posedge mclk) disable iff (!rstn)
        $rose(commandEnable) |-> (!addr4Byte && !deepPowerDown
            && $past(writeEnableLatchClear));
    endproperty
    a_defaults: assert property (p_defaults) else $error("bad defaults");
endmodule : frpc_reset_poweron
`default_nettype wire

// File: core/frpc_pkg.sv
// Constants for the flash reset and power-on sequencing block.
// Assumes a single 25 MHz clock and plain-port control signals.
//
// Notes on behaviour
// - Reset low at least 10 us resets
// - After reset: standby, volatile bits cleared, 3-byte
// - Reset aborts running program or erase
// - Serial output floats while reset held
// - Recovery 40/40/310 us by interrupted work
// - Erase recovery 12/25/1000 ms by size
// - Status/config write recovery 40 ms
// - Power-up into standby, latch cleared
// - Below inhibit threshold: held reset, ignore commands
package frpc_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned RESET_LOW_WIDTH_US = 10;
    localparam int unsigned RESET_TO_SELECT_DELAY_US = 10;
    localparam int unsigned POWERON_RECOVERY_US = 35;
    localparam int unsigned DECODE_RECOVERY_US = 40;
    localparam int unsigned READ_RECOVERY_US = 40;
    localparam int unsigned PROGRAM_RECOVERY_US = 310;
    localparam int unsigned SECTOR_ERASE_4K_RECOVERY_MS = 12;
    localparam int unsigned BLOCK_ERASE_RECOVERY_MS = 25;
    localparam int unsigned CHIP_ERASE_RECOVERY_MS = 1000;
    localparam int unsigned STATUS_CONFIG_WRITE_RECOVERY_MS = 40;
    localparam int unsigned SUPPLY_SETTLE_DELAY_US = 800;
    // Cycle counts: times scaled by whole cycles per unit, rounded down
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;
    localparam int unsigned RESET_LOW_WIDTH_CYC =
        RESET_LOW_WIDTH_US * CYC_PER_US;
    localparam int unsigned POWERON_RECOVERY_CYC =
        POWERON_RECOVERY_US * CYC_PER_US;
    localparam int unsigned DECODE_RECOVERY_CYC =
        DECODE_RECOVERY_US * CYC_PER_US;
    localparam int unsigned READ_RECOVERY_CYC = READ_RECOVERY_US * CYC_PER_US;
    localparam int unsigned PROGRAM_RECOVERY_CYC =
        PROGRAM_RECOVERY_US * CYC_PER_US;
    localparam int unsigned SECTOR_ERASE_4K_RECOVERY_CYC =
        SECTOR_ERASE_4K_RECOVERY_MS * CYC_PER_MS;
    localparam int unsigned BLOCK_ERASE_RECOVERY_CYC =
        BLOCK_ERASE_RECOVERY_MS * CYC_PER_MS;
    localparam int unsigned CHIP_ERASE_RECOVERY_CYC =
        CHIP_ERASE_RECOVERY_MS * CYC_PER_MS;
    localparam int unsigned STATUS_CONFIG_WRITE_RECOVERY_CYC =
        STATUS_CONFIG_WRITE_RECOVERY_MS * CYC_PER_MS;
    localparam int unsigned SUPPLY_SETTLE_DELAY_CYC =
        SUPPLY_SETTLE_DELAY_US * CYC_PER_US;
    localparam int CNT_W = 32;
    // Interrupted-operation codes
    localparam logic [2:0] OP_IDLE = 3'h0;
    localparam logic [2:0] OP_DECODE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_PROGRAM = 3'h3;
    localparam logic [2:0] OP_SECTOR_ERASE_4K = 3'h4;
    localparam logic [2:0] OP_BLOCK_ERASE = 3'h5;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h6;
    localparam logic [2:0] OP_STATUS_CONFIG_WRITE = 3'h7;
    // Sequencer states
    typedef enum logic [2:0] {
        FRPC_POWER_OFF = 3'b000,
        FRPC_SETTLE = 3'b001,
        FRPC_STANDBY = 3'b010,
        FRPC_RESET_LOW = 3'b011,
        FRPC_RECOVER = 3'b100
    } frpc_state_e;
endpackage : frpc_pkg

// File: core/frpc_sync3.sv
// Three-stage pin synchroniser with agreement of the last two stages.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module frpc_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // Change counts only when stages two and three agree
    always_comb
    begin
        next_level = level;
        if (s2 == s3)
        begin
            next_level = s3;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            level <= RESET_VAL;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule : frpc_sync3
`default_nettype wire

// File: verification/frpc_host_model.sv
// Host flash controller model: drives reset pin, select and supply flags.
// Assumes the bench calls its tasks and judges the device on its own.
`timescale 1ns/100ps
`default_nettype none
module frpc_host_model (
    input wire logic mclk,
    output logic resetPinN,
    output logic selectN,
    output logic supplyAboveInhibit,
    output logic supplyAboveMin
);
    // Supplies low, select released while power is not valid
    initial
    begin
        resetPinN = 1'b1;
        selectN = 1'b1;
        supplyAboveInhibit = 1'b0;
        supplyAboveMin = 1'b0;
    end
    // Both comparators move together; a real ramp would stagger them
    task automatic power(input logic on);
        @(posedge mclk);
        supplyAboveInhibit <= on;
        supplyAboveMin <= on;
    endtask : power
    // Reset pin low for n cycles
    task automatic pulse(input int n);
        @(posedge mclk);
        resetPinN <= 1'b0;
        repeat (n) @(posedge mclk);
        resetPinN <= 1'b1;
    endtask : pulse
    // Select frame after gap cycles; a gap under 250 breaks the wait
    task automatic frame(input int gap, input int n);
        repeat (gap) @(posedge mclk);
        selectN <= 1'b0;
        repeat (n) @(posedge mclk);
        selectN <= 1'b1;
    endtask : frame
endmodule : frpc_host_model
`default_nettype wire

// File: verification/flash_reset_poweron_control_tb.sv
// Self-checking bench for the reset and power-on sequencer.
// Assumes shortened erase, status-write and settle counts.
`timescale 1ns/100ps
`default_nettype none
module flash_reset_poweron_control_tb;
    localparam int SEC = 100;
    localparam int BLK = 120;
    localparam int CHP = 140;
    localparam int STW = 160;
    localparam int SET = 100;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] activeOp = 3'h0;
    logic coreDataOut = 1'b0;
    logic coreDataOutEn = 1'b1;
    logic [31:0] seed = 32'h7710304C;
    logic bitVal;
    wire resetPinN, selectN, supplyAboveInhibit, supplyAboveMin;
    wire dataOut, dataOutEn, coreResetN, abortOp, busy, commandEnable;
    wire readEnable, writeEnableLatchClear, addr4Byte, deepPowerDown;
    int fail_count = 0;
    int check_count = 0;
    int abortCnt = 0;
    int n;
    always #20 mclk = ~mclk;
    frpc_host_model frpc_host_model_i (.mclk(mclk), .resetPinN(resetPinN),
        .selectN(selectN), .supplyAboveInhibit(supplyAboveInhibit),
        .supplyAboveMin(supplyAboveMin));
    frpc_reset_poweron #(.SECTOR_ERASE_CYC(SEC), .BLOCK_ERASE_CYC(BLK),
        .CHIP_ERASE_CYC(CHP), .STATUS_WRITE_CYC(STW), .SETTLE_CYC(SET))
    frpc_reset_poweron_i (.mclk(mclk), .rstn(rstn), .resetPinN(resetPinN),
        .selectN(selectN), .supplyAboveInhibit(supplyAboveInhibit),
        .supplyAboveMin(supplyAboveMin), .activeOp(activeOp),
        .coreDataOut(coreDataOut), .coreDataOutEn(coreDataOutEn),
        .dataOut(dataOut), .dataOutEn(dataOutEn), .coreResetN(coreResetN),
        .abortOp(abortOp), .busy(busy), .commandEnable(commandEnable),
        .readEnable(readEnable),
        .writeEnableLatchClear(writeEnableLatchClear),
        .addr4Byte(addr4Byte), .deepPowerDown(deepPowerDown));
    // Abort pulses counted away from the launching edge
    always @(negedge mclk)
        if (abortOp === 1'b1)
            abortCnt++;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Reference recovery length by interrupted operation
    function automatic int rec(input int op);
        case (op)
            0, 1, 2: return 1000;
            3: return 7750;
            4: return SEC;
            5: return BLK;
            6: return CHP;
            default: return STW;
        endcase
    endfunction : rec
    task automatic chkb(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask : chkb
    task automatic chki(input int got, input int lo, input int hi,
        input string m);
        check_count++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("BAD t=%0t %s got %0d", $time, m, got);
        end
    endtask : chki
    // Bounded wait for command acceptance, counted in cycles
    task automatic waitCmd(output int c);
        c = 0;
        while (commandEnable !== 1'b1 && c < 20000)
        begin
            @(negedge mclk);
            c++;
        end
    endtask : waitCmd
    task automatic pwrUp();
        frpc_host_model_i.power(1'b1);
        waitCmd(n);
        chki(n, SET + 875, SET + 883, "power-up time");
        chkb(deepPowerDown, 1'b0, "deep power-down");
        chkb(busy, 1'b0, "busy after power-up");
        $display("test power-up done");
    endtask : pwrUp
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        $display("BAD t=%0t watchdog", $time);
        finish_test();
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        chkb(busy, 1'b1, "busy unpowered");
        chkb(commandEnable, 1'b0, "deaf unpowered");
        pwrUp();
        // Every interrupted operation, random pulse width
        for (int op = 0; op < 8; op++)
        begin
            @(posedge mclk);
            activeOp <= op[2:0];
            abortCnt = 0;
            // Select held low so the float check can really trip
            fork
                frpc_host_model_i.pulse(260 + int'(xs() % 64));
                frpc_host_model_i.frame(0, 30);
                begin
                    repeat (20) @(negedge mclk);
                    chkb(dataOutEn, 1'b0, "output floats");
                    chkb(coreResetN, 1'b0, "core held");
                    chkb(writeEnableLatchClear, 1'b1, "latch clear");
                end
            join
            chki(abortCnt, op >= 3, op >= 3, "abort count");
            // Select after the reset-to-select wait; still inside the
            // longer recoveries, where it must be ignored
            fork
                waitCmd(n);
                frpc_host_model_i.frame(260, 30);
            join
            chki(n, rec(op), rec(op) + 8, "recovery");
            chkb(addr4Byte, 1'b0, "3-byte mode");
            bitVal = xs() % 2;
            @(posedge mclk);
            coreDataOut <= bitVal;
            // Output only drives while selected, so open a frame
            fork
                frpc_host_model_i.frame(0, 8);
                begin
                    repeat (7) @(negedge mclk);
                    chkb(dataOut, bitVal, "data path");
                    chkb(dataOutEn, 1'b1, "drive in standby");
                    chkb(readEnable, 1'b1, "reads accepted");
                end
            join
            $display("test op %0d done", op);
        end
        // Pulse below minimum width does not start a recovery
        @(posedge mclk);
        activeOp <= 3'h0;
        frpc_host_model_i.pulse(100);
        waitCmd(n);
        chki(n, 0, 12, "short pulse");
        // Widths just under and at the minimum
        frpc_host_model_i.pulse(249);
        waitCmd(n);
        chki(n, 0, 12, "just under minimum");
        frpc_host_model_i.pulse(250);
        waitCmd(n);
        chki(n, rec(0), rec(0) + 8, "minimum width resets");
        $display("test short pulse done");
        // Supply drop forces the device deaf, then power comes back
        frpc_host_model_i.power(1'b0);
        repeat (6) @(negedge mclk);
        chkb(commandEnable, 1'b0, "deaf below inhibit");
        chkb(coreResetN, 1'b0, "held below inhibit");
        pwrUp();
        finish_test();
    end
endmodule : flash_reset_poweron_control_tb
`default_nettype wire
